// ===== lvc_defs.vh
// Constants for the LED forward-voltage self-calibration block
// Behaviour
// - A write of the calibration start/done bit starts a new cycle.
// - Every cycle starts with the output voltage target at its lowest value.
// - Only sinks enabled by the LED sink enable bits are checked.
// - The result follows the enabled sink with the largest forward voltage.
// - The voltage steps automatically with a flash at the set currents.
// - The sweep ends at the first code giving all enabled sinks headroom, or at code 1111 if none does.
// - At the stop the final code is written to the 4-bit voltage field.
// - Completion sets the calibration bit, cleared only by a new start.
// - While that bit is set the voltage field holds the last result.
// - Code 0000 is 3.825V, each step adds 0.125V, up to 1111 at 5.700V.
`ifndef LVC_DEFS_VH
`define LVC_DEFS_VH
`define LVC_CLOCK_MHZ 25
`define LVC_FLASH_NS 2000
`define LVC_SETTLE_NS 1000
`define LVC_OV_MIN 4'h0
`define LVC_OV_MAX 4'hF
`define LVC_OV_BASE_MV 3825
`define LVC_OV_STEP_MV 125
`define LVC_HEADROOM_MV 400
`define LVC_MODE_PREFERRED 2'h0
`define LVC_ADDR_CTRL 12'h000
`define LVC_ADDR_CURR 12'h004
`define LVC_ADDR_STATUS 12'h008
`define LVC_ADDR_IRQ_STATUS 12'h00C
`define LVC_ADDR_IRQ_MASK 12'h010
`define LVC_CTRL_CAL_BIT 0
`define LVC_CTRL_VREG_BIT 1
`define LVC_CTRL_MODE_LSB 2
`define LVC_CTRL_LED_LSB 4
`define LVC_CTRL_OV_LSB 8
`define LVC_CURR_C13_LSB 0
`define LVC_CURR_C2_LSB 8
`define LVC_IRQ_DONE_BIT 0
`define LVC_IRQ_NOHR_BIT 1
`define LVC_STATUS_STATE_LSB 0
`define LVC_STATUS_SINK_LSB 4
`define LVC_STATUS_OV_LSB 8
`endif

// ===== lvc_timer.v
// Cycle timer used for flash and settle intervals
`timescale 1ns/10ps
module lvc_timer #(
  parameter WIDTH = 8
) (
  input wire clock,
  input wire reset,
  input wire start,
  input wire [WIDTH-1:0] load,
  output wire expired
);
  reg [WIDTH-1:0] count;
  reg running;
  // Count down from load, expire pulse on reaching one
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= {WIDTH{1'b0}};
      running <= 1'b0;
    end else if (start) begin
      count <= load;
      running <= 1'b1;
    end else if (running) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      if (count <= {{(WIDTH-1){1'b0}}, 1'b1})
        running <= 1'b0;
    end
  end
  assign expired = running && (count <= {{(WIDTH-1){1'b0}}, 1'b1});
endmodule

// ===== lvc_sync.v
// Two-stage synchroniser for the sink headroom comparator inputs
`timescale 1ns/10ps
module lvc_sync #(
  parameter WIDTH = 3
) (
  input wire clock,
  input wire reset,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  // First stage read only by the second
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ===== lvc_calibration.v
// Forward-voltage self-calibration sequencer with AHB-Lite registers
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "lvc_defs.vh"
module lvc_calibration #(
  parameter SINKS = 3,
  parameter FLASH_NS = `LVC_FLASH_NS,
  parameter SETTLE_NS = `LVC_SETTLE_NS
) (
  input wire clock,
  input wire reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [SINKS-1:0] headroom_ok,
  output reg [3:0] output_voltage_target,
  output reg flash_pulse,
  output reg [4:0] flash_current_sinks_1_3,
  output reg [5:0] flash_current_sink_2,
  output reg [SINKS-1:0] flash_sink_enable,
  output reg calibration_busy,
  output reg [1:0] operating_mode,
  output reg voltage_regulation_enable,
  output wire irq
);
  ////////////////////////////////////////////////////////////////////////
  // Timing counts derived from clock rate
  localparam integer FLASH_CYC_RAW = (FLASH_NS * `LVC_CLOCK_MHZ) / 1000;
  localparam integer SETTLE_CYC_RAW = (SETTLE_NS * `LVC_CLOCK_MHZ) / 1000;
  localparam integer FLASH_CYC = (FLASH_CYC_RAW < 1) ? 1 : FLASH_CYC_RAW;
  localparam integer SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
  localparam TW = 12;
  localparam [TW-1:0] FLASH_LOAD = FLASH_CYC[TW-1:0];
  localparam [TW-1:0] SETTLE_LOAD = SETTLE_CYC[TW-1:0];
  // Sequencer states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETTLE = 3'h1;
  localparam [2:0] ST_FLASH = 3'h2;
  localparam [2:0] ST_CHECK = 3'h3;
  localparam [2:0] ST_STEP = 3'h4;
  localparam [2:0] ST_DONE = 3'h5;

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  function is_addr;
    input [31:0] a;
    input [11:0] off;
    begin
      is_addr = (a[11:0] == off) && (a[31:12] == 20'h00000);
    end
  endfunction

  // Sweep ends on full headroom or at the top code
  function sweep_end;
    input ok;
    input [3:0] code;
    begin
      sweep_end = ok || (code == `LVC_OV_MAX);
    end
  endfunction

  reg [2:0] state;
  reg [2:0] next_state;
  reg cal_done;
  reg [SINKS-1:0] led_sink_enables;
  reg [3:0] output_voltage_code;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg [SINKS-1:0] worst_sink;
  reg ph_write;
  reg [31:0] ph_addr;
  wire [SINKS-1:0] headroom_sync;
  wire timer_expired;
  wire timer_start;
  wire [TW-1:0] timer_load;
  wire acc;
  wire wr_ctrl;
  wire cal_write;
  wire all_ok;
  wire [SINKS-1:0] short_sinks;
  reg ev_done;
  reg ev_nohr;
  wire [1:0] irq_event;
  wire [1:0] next_irq_status;
  wire irq_clear;

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel && hready && htrans[1];
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ph_write <= 1'b0;
      ph_addr <= 32'h00000000;
    end else begin
      ph_write <= acc && hwrite;
      ph_addr <= haddr;
    end
  end
  assign wr_ctrl = ph_write && is_addr(ph_addr, `LVC_ADDR_CTRL);
  assign cal_write = wr_ctrl && hwdata[`LVC_CTRL_CAL_BIT];

  // Read data register, loaded in the address phase
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (acc && !hwrite) begin
      hrdata <= 32'h00000000;
      if (is_addr(haddr, `LVC_ADDR_CTRL)) begin
        hrdata[`LVC_CTRL_CAL_BIT] <= cal_done;
        hrdata[`LVC_CTRL_VREG_BIT] <= voltage_regulation_enable;
        hrdata[`LVC_CTRL_MODE_LSB+:2] <= operating_mode;
        hrdata[`LVC_CTRL_LED_LSB+:SINKS] <= led_sink_enables;
        hrdata[`LVC_CTRL_OV_LSB+:4] <= output_voltage_code;
      end else if (is_addr(haddr, `LVC_ADDR_CURR)) begin
        hrdata[`LVC_CURR_C13_LSB+:5] <= flash_current_sinks_1_3;
        hrdata[`LVC_CURR_C2_LSB+:6] <= flash_current_sink_2;
      end else if (is_addr(haddr, `LVC_ADDR_STATUS)) begin
        hrdata[`LVC_STATUS_STATE_LSB+:3] <= state;
        hrdata[`LVC_STATUS_SINK_LSB+:SINKS] <= worst_sink;
        hrdata[`LVC_STATUS_OV_LSB+:4] <= output_voltage_target;
      end else if (is_addr(haddr, `LVC_ADDR_IRQ_STATUS)) begin
        hrdata[1:0] <= irq_status;
      end else if (is_addr(haddr, `LVC_ADDR_IRQ_MASK)) begin
        hrdata[1:0] <= irq_mask;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software-written configuration
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      voltage_regulation_enable <= 1'b0;
      operating_mode <= `LVC_MODE_PREFERRED;
      led_sink_enables <= {SINKS{1'b1}};
      flash_current_sinks_1_3 <= 5'h00;
      flash_current_sink_2 <= 6'h00;
      irq_mask <= 2'h0;
    end else if (ph_write) begin
      if (is_addr(ph_addr, `LVC_ADDR_CTRL)) begin
        // Mode 00 and regulation off is the software's job
        voltage_regulation_enable <= hwdata[`LVC_CTRL_VREG_BIT];
        operating_mode <= hwdata[`LVC_CTRL_MODE_LSB+:2];
        led_sink_enables <= hwdata[`LVC_CTRL_LED_LSB+:SINKS];
      end
      if (is_addr(ph_addr, `LVC_ADDR_CURR)) begin
        flash_current_sinks_1_3 <= hwdata[`LVC_CURR_C13_LSB+:5];
        flash_current_sink_2 <= hwdata[`LVC_CURR_C2_LSB+:6];
      end
      if (is_addr(ph_addr, `LVC_ADDR_IRQ_MASK))
        irq_mask <= hwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Headroom comparators come from analog, synchronise them
  lvc_sync #(.WIDTH(SINKS)) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in(headroom_ok),
    .sync_out(headroom_sync)
  );
  // Per-sink shortfall; disabled sinks never block the stop condition
  genvar g;
  generate
    for (g = 0; g < SINKS; g = g + 1) begin : g_sink
      assign short_sinks[g] = led_sink_enables[g] & ~headroom_sync[g];
    end
  endgenerate
  // Worst sink decides: any enabled sink still short holds the sweep
  assign all_ok = (short_sinks == {SINKS{1'b0}});

  // Shared interval timer
  assign timer_start = (state == ST_IDLE && cal_write) ||
                       (state == ST_STEP) ||
                       (state == ST_SETTLE && timer_expired);
  assign timer_load = (state == ST_SETTLE) ? FLASH_LOAD : SETTLE_LOAD;
  lvc_timer #(.WIDTH(TW)) u_timer (
    .clock(clock),
    .reset(reset),
    .start(timer_start),
    .load(timer_load),
    .expired(timer_expired)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cal_write)
          next_state = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (timer_expired)
          next_state = ST_FLASH;
      end
      ST_FLASH: begin
        if (timer_expired)
          next_state = ST_CHECK;
      end
      ST_CHECK: begin
        if (sweep_end(all_ok, output_voltage_target))
          next_state = ST_DONE;
        else
          next_state = ST_STEP;
      end
      ST_STEP: begin
        next_state = ST_SETTLE;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      output_voltage_target <= `LVC_OV_MIN;
      output_voltage_code <= `LVC_OV_MIN;
      cal_done <= 1'b0;
      flash_pulse <= 1'b0;
      flash_sink_enable <= {SINKS{1'b0}};
      calibration_busy <= 1'b0;
      worst_sink <= {SINKS{1'b0}};
      ev_done <= 1'b0;
      ev_nohr <= 1'b0;
    end else begin
      state <= next_state;
      ev_done <= 1'b0;
      ev_nohr <= 1'b0;
      flash_pulse <= (next_state == ST_FLASH);
      flash_sink_enable <= (next_state == ST_FLASH) ?
                           led_sink_enables : {SINKS{1'b0}};
      case (state)
        ST_IDLE: begin
          if (cal_write) begin
            output_voltage_target <= `LVC_OV_MIN;
            cal_done <= 1'b0;
            calibration_busy <= 1'b1;
            worst_sink <= {SINKS{1'b0}};
          end
        end
        ST_CHECK: begin
          // Remember sinks still short of headroom at this step
          if (!all_ok)
            worst_sink <= short_sinks;
          if (sweep_end(all_ok, output_voltage_target)) begin
            output_voltage_code <= output_voltage_target;
            ev_nohr <= !all_ok;
          end
        end
        ST_STEP: begin
          // One code step is one fixed converter voltage increment
          output_voltage_target <= output_voltage_target + 4'h1;
        end
        ST_DONE: begin
          cal_done <= 1'b1;
          calibration_busy <= 1'b0;
          ev_done <= 1'b1;
        end
        default: begin
          calibration_busy <= calibration_busy;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events routed to their status bit positions
  assign irq_event[`LVC_IRQ_DONE_BIT] = ev_done;
  assign irq_event[`LVC_IRQ_NOHR_BIT] = ev_nohr;
  assign irq_clear = ph_write && is_addr(ph_addr, `LVC_ADDR_IRQ_STATUS);
  // Next status per bit: the event wins over a write-one clear
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_irq
      assign next_irq_status[g] = irq_event[g] |
        (irq_status[g] & ~(irq_clear & hwdata[g]));
    end
  endgenerate
  // Sticky interrupt status register
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= next_irq_status;
    end
  end
  // Level interrupt while any unmasked status bit is set
  assign irq = |(irq_status & irq_mask);
endmodule

// ===== lvc_calibration_checker.sv
// Assertion checker for the calibration sequencer ports
`timescale 1ns/10ps
`include "lvc_defs.vh"
module lvc_calibration_checker #(
  parameter SINKS = 3,
  parameter FLASH_NS = 2000,
  parameter SETTLE_NS = 1000
) (
  input wire clock,
  input wire reset,
  input wire hreadyout,
  input wire hresp,
  input wire [3:0] output_voltage_target,
  input wire flash_pulse,
  input wire [SINKS-1:0] flash_sink_enable,
  input wire calibration_busy
);
  localparam int FL = FLASH_NS * `LVC_CLOCK_MHZ / 1000;
  int flash_len;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  // Length of the current flash in cycles
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      flash_len <= 0;
    end else begin
      flash_len <= flash_pulse ? flash_len + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  start_code_a: assert property ($rose(calibration_busy) |->
    output_voltage_target == 4'h0) else $error("sweep not at lowest code");
  one_step_a: assert property (
    calibration_busy && $past(calibration_busy) &&
    $changed(output_voltage_target) |-> output_voltage_target ==
    $past(output_voltage_target) + 4'h1) else $error("step not by one");
  flash_busy_a: assert property (flash_pulse |-> calibration_busy)
    else $error("flash outside calibration");
  sink_idle_a: assert property (
    !flash_pulse |-> flash_sink_enable == '0)
    else $error("sinks enabled outside flash");
  flash_len_a: assert property (
    $fell(flash_pulse) |-> flash_len == FL)
    else $error("flash length wrong");
  flash_code_a: assert property (flash_pulse && $past(flash_pulse) |->
    $stable(output_voltage_target)) else $error("code moved in flash");
  result_hold_a: assert property (!calibration_busy &&
    !$past(calibration_busy) |-> $stable(output_voltage_target))
    else $error("result changed while idle");
endmodule
bind lvc_calibration lvc_calibration_checker #(.SINKS(SINKS),
  .FLASH_NS(FLASH_NS), .SETTLE_NS(SETTLE_NS)) u_chk (.clock(clock),
  .reset(reset), .hreadyout(hreadyout), .hresp(hresp),
  .output_voltage_target(output_voltage_target), .flash_pulse(flash_pulse),
  .flash_sink_enable(flash_sink_enable),
  .calibration_busy(calibration_busy));

// ===== lvc_calibration_tb.sv
// Self-checking testbench for the calibration sequencer
`timescale 1ns/10ps
`include "lvc_defs.vh"
module lvc_calibration_tb;
  logic clock, reset, hsel, hwrite, hready, flash_pulse, irq, busy;
  logic hreadyout, hresp, vreg;
  logic [1:0] htrans, mode;
  logic [2:0] hsize, headroom_ok, fse;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [3:0] ovt;
  logic [4:0] fc13;
  logic [5:0] fc2;
  int fails, checks, seed, thr[3], leds, c13, c2, msk, nfl, ex, nohr;
  int md, lf, ws;
  bit pf;
  lvc_calibration u_dut (.clock(clock), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .headroom_ok(headroom_ok), .output_voltage_target(ovt),
    .flash_pulse(flash_pulse), .flash_current_sinks_1_3(fc13),
    .flash_current_sink_2(fc2), .flash_sink_enable(fse),
    .calibration_busy(busy), .operating_mode(mode),
    .voltage_regulation_enable(vreg), .irq(irq));
  ////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One AHB-Lite single word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and sink headroom model
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    stop_test;
  end
  always @(posedge clock) begin
    for (int k = 0; k < 3; k++) headroom_ok[k] <= (ovt >= thr[k]);
  end
  // Flash watch: count flashes and check currents at each start
  always @(negedge clock) begin
    if (flash_pulse === 1'b1 && !pf) begin
      nfl++;
      chk("fc13", fc13, c13);
      chk("fc2", fc2, c2);
      chk("sinks", fse, leds);
    end
    pf = (flash_pulse === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 44;
    reset = 1;
    hsel = 1;
    hready = 1;
    hsize = 3'h2;
    htrans = 2'h0;
    hwrite = 0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (16) @(posedge clock);
    reset <= 0;
    @(posedge clock);
    bus(0, 32'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    for (int i = 0; i < 12; i++) begin
      for (int k = 0; k < 3; k++) thr[k] = {$random(seed)} % 18;
      leds = {$random(seed)} % 8;
      c13 = {$random(seed)} % 32;
      c2 = {$random(seed)} % 64;
      msk = {$random(seed)} % 4;
      md = {$random(seed)} % 8;
      bus(1, `LVC_ADDR_CURR, (c2 << 8) | c13);
      bus(1, `LVC_ADDR_IRQ_MASK, msk);
      bus(1, `LVC_ADDR_CTRL, (leds << 4) | (md << 1)); // Start bit low
      bus(0, `LVC_ADDR_CTRL, 0);
      chk("idle", busy, 0);
      chk("held", rd[11:8], ex);
      chk("ctrl_rd", rd[3:1], md);
      chk("mode", mode, md >> 1);
      chk("vreg", vreg, md & 1);
      nfl = 0;
      bus(1, `LVC_ADDR_CTRL, (leds << 4) | 1); // Mode 00, no regulation
      bus(0, `LVC_ADDR_CTRL, 0);
      chk("busy", busy, 1);
      chk("done_clear", rd[0], 0);
      while (busy !== 1'b0) @(posedge clock);
      ex = 0;
      for (int k = 0; k < 3; k++) begin
        if (leds[k] && thr[k] > ex) ex = thr[k];
      end
      nohr = (ex > 15);
      if (nohr) ex = 15;
      // Sinks still short at the last code that failed the check
      lf = nohr ? 15 : ex - 1;
      ws = 0;
      for (int k = 0; k < 3; k++) begin
        if (leds[k] && lf >= 0 && thr[k] > lf) ws |= 1 << k;
      end
      bus(0, `LVC_ADDR_CTRL, 0);
      chk("done", rd[0], 1);
      chk("code", rd[11:8], ex);
      chk("leds", rd[6:4], leds);
      chk("flashes", nfl, ex + 1);
      bus(0, `LVC_ADDR_STATUS, 0);
      chk("state", rd[2:0], 0);
      chk("short", rd[6:4], ws);
      chk("target", rd[11:8], ex);
      chk("ovt", ovt, ex);
      bus(0, `LVC_ADDR_IRQ_STATUS, 0);
      chk("irq_stat", rd[1:0], {nohr[0], 1'b1});
      @(negedge clock);
      chk("irq", irq, |({nohr[0], 1'b1} & msk[1:0]));
      @(posedge clock);
      bus(1, `LVC_ADDR_IRQ_STATUS, 32'h3);
      bus(0, `LVC_ADDR_IRQ_STATUS, 0);
      chk("irq_clr", rd[1:0], 0);
      chk("irq_low", irq, 0);
    end
    stop_test;
  end
endmodule
